// ---- timer16_pkg.sv ----
/*
 * Package for the 16-bit timer waveform-mode and compare-output block:
 * register offsets, field positions, reset values, mode codes, carriers.
 * Assumes a single 40 MHz clock and an AXI4-Lite register bus.
 */
package timer16_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL_A  = 8'h80;
	localparam logic [7:0] OFF_CONTROL_B  = 8'h81;
	localparam logic [7:0] OFF_CONTROL_B_W = 8'h84;
	localparam logic [7:0] OFF_COMPARE_A  = 8'h88;
	localparam logic [7:0] OFF_COMPARE_B  = 8'h8C;
	localparam logic [7:0] OFF_CAPTURE    = 8'h90;
	localparam logic [7:0] OFF_COUNT      = 8'h94;
	localparam logic [7:0] OFF_FLAGS      = 8'h98;

	// Control A field positions and reset value
	localparam int CA_ACT_A_LSB = 6;
	localparam int CA_ACT_B_LSB = 4;
	localparam int CA_WGM_LSB   = 0;
	localparam logic [7:0] CONTROL_A_RESET = 8'h00;
	localparam logic [7:0] CONTROL_A_MASK  = 8'hF3;
	// Control B (own word): bits 4:3 high mode, 2:0 tick source
	localparam int CB_WGM_LSB = 3;
	localparam int CB_CS_LSB  = 0;
	localparam logic [7:0] CONTROL_B_RESET = 8'h00;
	localparam logic [7:0] CONTROL_B_MASK  = 8'h1F;
	// Flag bits: 0 overflow, 1 match A, 2 match B
	localparam int FL_OVF = 0;
	localparam int FL_CMA = 1;
	localparam int FL_CMB = 2;

	// Counter limits
	localparam logic [15:0] BOTTOM   = 16'h0000;
	localparam logic [15:0] MAX      = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;

	// Prescale divide counts
	localparam logic [9:0] DIV_8    = 10'h007;
	localparam logic [9:0] DIV_64   = 10'h03F;
	localparam logic [9:0] DIV_256  = 10'h0FF;
	localparam logic [9:0] DIV_1024 = 10'h3FF;

	// Output action codes
	localparam logic [1:0] ACT_OFF    = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// Tick source codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Waveform class, one-hot
	typedef enum logic [4:0] {
		WF_NORMAL = 5'h01,
		WF_CTC    = 5'h02,
		WF_FAST   = 5'h04,
		WF_DUAL   = 5'h08,
		WF_RSVD   = 5'h10
	} wave_class_t;

	// Update point of compare values
	typedef enum logic [2:0] {
		UPD_NOW    = 3'h1,
		UPD_TOP    = 3'h2,
		UPD_BOTTOM = 3'h4
	} update_at_t;

	// Decoded mode bundle
	typedef struct packed {
		wave_class_t cls;
		update_at_t  upd;
		logic [1:0]  top_src;   // 0 fixed, 1 capture, 2 compare A
		logic [15:0] fixed_top;
		logic        ovf_bottom; // overflow at BOTTOM instead of TOP/MAX
		logic        toggle_ok;  // channel A toggle allowed in PWM
	} mode_info_t;

	// Compare outputs to the pin mux
	typedef struct packed {
		logic level;
		logic connect;
	} pin_ctl_t;

endpackage

// ---- wave_unit.sv ----
/*
 * Compare-output waveform unit for one channel.
 * Assumes tick and match strobes qualified by the same clock enable.
 */
`timescale 1ns/1ps
module wave_unit
	import timer16_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        resetn_in,
	// Control
	input  wire logic [1:0]  action_in,
	input  wire mode_info_t  mode_in,
	input  wire logic        is_chan_a_in,
	// Events
	input  wire logic        tick_in,
	input  wire logic        match_in,
	input  wire logic        at_bottom_in,
	input  wire logic        match_is_top_in,
	input  wire logic        count_up_in,
	// Output
	output pin_ctl_t         pin_out
);
	import timer16_pkg::*;

	logic level_r;   // Output latch
	logic level_nxt; // Next latch value
	logic conn_r;    // Pin override
	logic conn_nxt;  // Next override

	// Next level from action, class and events
	always_comb begin
		level_nxt = level_r;
		conn_nxt  = 1'b0;
		case (mode_in.cls)
			WF_NORMAL, WF_CTC: begin
				conn_nxt = (action_in != ACT_OFF);
				if (tick_in && match_in) begin
					case (action_in)
						ACT_TOGGLE: level_nxt = ~level_r;
						ACT_CLEAR:  level_nxt = 1'b0;
						ACT_SET:    level_nxt = 1'b1;
						default:    level_nxt = level_r;
					endcase
				end
			end
			WF_FAST: begin
				if (action_in == ACT_TOGGLE) begin
					// Toggle only channel A in capture- or compare-A-as-TOP modes
					conn_nxt = is_chan_a_in && mode_in.toggle_ok;
					if (conn_nxt && tick_in && match_in)
						level_nxt = ~level_r;
				end else if (action_in[1]) begin
					conn_nxt = 1'b1;
					if (tick_in && at_bottom_in)
						level_nxt = ~action_in[0];
					else if (tick_in && match_in && !match_is_top_in)
						level_nxt = action_in[0];
				end
			end
			WF_DUAL: begin
				if (action_in == ACT_TOGGLE) begin
					conn_nxt = is_chan_a_in && mode_in.toggle_ok;
					if (conn_nxt && tick_in && match_in)
						level_nxt = ~level_r;
				end else if (action_in[1]) begin
					conn_nxt = 1'b1;
					// Direction decides polarity; BOTTOM/TOP match gives
					// constant level since the match recurs each period
					if (tick_in && match_in)
						level_nxt = count_up_in ? action_in[0]
							: ~action_in[0];
				end
			end
			default: begin
				conn_nxt  = 1'b0; // Reserved mode leaves pin alone
				level_nxt = level_r;
			end
		endcase
	end

	// Register output state
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_r <= 1'b0;
			conn_r  <= 1'b0;
		end else begin
			level_r <= level_nxt;
			conn_r  <= conn_nxt;
		end
	end

	assign pin_out.level   = level_r;
	assign pin_out.connect = conn_r;

endmodule

// ---- timer16_core.sv ----
/*
 * Top of the 16-bit timer waveform-mode block: AXI4-Lite registers,
 * prescaler, counter sequencer, flags and two compare-output units.
 * Assumes the external tick pin and port pins are asynchronous.
 */
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module timer16_core
	import timer16_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        resetn_in,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [7:0]  s_axi_awaddr_in,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	// AXI4-Lite write response
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	output logic [1:0]       s_axi_bresp_out,
	// AXI4-Lite read
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	input  wire logic [7:0]  s_axi_araddr_in,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	// Pins
	input  wire logic        ext_tick_pin_in,
	input  wire logic        port_a_level_in,
	input  wire logic        port_b_level_in,
	output logic             compare_out_a_out,
	output logic             compare_out_b_out
);
	import timer16_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Registers and bus state
	logic [7:0]  ctrl_a_r, ctrl_a_nxt;     // Control A
	logic [7:0]  ctrl_b_r, ctrl_b_nxt;     // Control B
	logic [15:0] cmp_a_buf_r, cmp_a_buf_nxt; // Compare A buffer
	logic [15:0] cmp_b_buf_r, cmp_b_buf_nxt; // Compare B buffer
	logic [15:0] cmp_a_r, cmp_a_nxt;       // Active compare A
	logic [15:0] cmp_b_r, cmp_b_nxt;       // Active compare B
	logic [15:0] capture_r, capture_nxt;   // Capture value
	logic [15:0] count_r, count_nxt;       // Counter
	logic        up_r, up_nxt;             // Dual-slope direction
	logic [2:0]  flags_r, flags_nxt;       // Sticky flags
	logic        match_a_r, match_a_nxt;   // Pending match A
	logic        match_b_r, match_b_nxt;   // Pending match B
	logic        aw_r, aw_nxt;             // Address held
	logic        w_r, w_nxt;               // Data held
	logic [7:0]  awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	logic [9:0]  pre_r, pre_nxt;           // Prescaler
	logic [2:0]  ext_sync_r;               // Pin sync and edge history
	logic        pin_a_r;                  // Pin outputs
	logic        pin_b_r;
	logic [1:0]  port_a_sync_r, port_b_sync_r;

	// Decode helpers
	logic [3:0]  wgm;
	mode_info_t  mode;
	logic [15:0] top;
	logic        tick;
	logic        do_write, wr_hit;
	logic        at_top, at_bottom;
	pin_ctl_t    ctl_a, ctl_b;

	assign wgm = {ctrl_b_r[CB_WGM_LSB +: 2], ctrl_a_r[CA_WGM_LSB +: 2]};

	////////////////////////////////////////////////////////////////////
	// Mode decode table
	always_comb begin
		mode = '{cls: WF_NORMAL, upd: UPD_NOW, top_src: 2'h0,
			fixed_top: MAX, ovf_bottom: 1'b0, toggle_ok: 1'b0};
		case (wgm)
			4'h0: mode.cls = WF_NORMAL;
			4'h4: begin mode.cls = WF_CTC; mode.top_src = 2'h2; end
			4'hC: begin mode.cls = WF_CTC; mode.top_src = 2'h1; end
			4'h1, 4'h2, 4'h3, 4'hA, 4'hB: begin
				mode.cls = WF_DUAL;
				mode.upd = UPD_TOP;
				mode.ovf_bottom = 1'b1;
				mode.top_src = (wgm == 4'hA) ? 2'h1
					: (wgm == 4'hB) ? 2'h2 : 2'h0;
				mode.fixed_top = (wgm == 4'h1) ? TOP_8BIT
					: (wgm == 4'h2) ? TOP_9BIT : TOP_10BIT;
				mode.toggle_ok = (wgm == 4'hB);
			end
			4'h8, 4'h9: begin
				mode.cls = WF_DUAL;
				mode.upd = UPD_BOTTOM;
				mode.ovf_bottom = 1'b1;
				mode.top_src = wgm[0] ? 2'h2 : 2'h1;
				mode.toggle_ok = wgm[0];
			end
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
				mode.cls = WF_FAST;
				mode.upd = UPD_BOTTOM;
				mode.top_src = (wgm == 4'hE) ? 2'h1
					: (wgm == 4'hF) ? 2'h2 : 2'h0;
				mode.fixed_top = (wgm == 4'h5) ? TOP_8BIT
					: (wgm == 4'h6) ? TOP_9BIT : TOP_10BIT;
				// Channel A toggle is legal in both register-as-TOP modes (capture in E, compare A in F)
				mode.toggle_ok = (wgm == 4'hE) || (wgm == 4'hF);
			end
			default: mode.cls = WF_RSVD;
		endcase
	end

	// TOP source pick
	always_comb begin
		case (mode.top_src)
			2'h1:    top = capture_r;
			2'h2:    top = cmp_a_r;
			default: top = mode.fixed_top;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Tick source: prescaler and synchronised external edges
	always_comb begin
		pre_nxt = pre_r + 10'h001;
		tick    = 1'b0;
		case (ctrl_b_r[CB_CS_LSB +: 3])
			CS_STOP:     pre_nxt = 10'h000;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = ((pre_r & DIV_8) == DIV_8);
			CS_DIV64:    tick = ((pre_r & DIV_64) == DIV_64);
			CS_DIV256:   tick = ((pre_r & DIV_256) == DIV_256);
			CS_DIV1024:  tick = (pre_r == DIV_1024);
			CS_EXT_FALL: tick = ext_sync_r[2] & ~ext_sync_r[1];
			CS_EXT_RISE: tick = ~ext_sync_r[2] & ext_sync_r[1];
			default:     tick = 1'b0;
		endcase
	end

	assign at_top    = (count_r == top);
	assign at_bottom = (count_r == BOTTOM);

	////////////////////////////////////////////////////////////////////
	// Counter, reloads and flags; qualified by the tick except flag clears and UPD_NOW reloads
	always_comb begin
		count_nxt = count_r;
		up_nxt    = up_r;
		cmp_a_nxt = cmp_a_r;
		cmp_b_nxt = cmp_b_r;
		flags_nxt = flags_r;
		// Write-one-to-clear first; a hardware set below still wins
		if (do_write && awaddr_r == OFF_FLAGS && wstrb_r[0])
			flags_nxt = flags_r & ~wdata_r[2:0];
		match_a_nxt = match_a_r;
		match_b_nxt = match_b_r;
		if (mode.upd == UPD_NOW) begin
			cmp_a_nxt = cmp_a_buf_r;
			cmp_b_nxt = cmp_b_buf_r;
		end
		if (tick) begin
			// Flag the match found on the previous tick
			if (match_a_r) flags_nxt[FL_CMA] = 1'b1;
			if (match_b_r) flags_nxt[FL_CMB] = 1'b1;
			match_a_nxt = (count_r == cmp_a_r);
			match_b_nxt = (count_r == cmp_b_r);
			case (mode.cls)
				WF_NORMAL: begin
					count_nxt = count_r + 16'h0001;
					if (count_r == MAX) flags_nxt[FL_OVF] = 1'b1;
				end
				WF_CTC: begin
					count_nxt = at_top ? BOTTOM : count_r + 16'h0001;
					if (count_r == MAX) flags_nxt[FL_OVF] = 1'b1;
				end
				WF_FAST: begin
					count_nxt = at_top ? BOTTOM : count_r + 16'h0001;
					if (at_top) begin
						flags_nxt[FL_OVF] = 1'b1;
						// Reload lands as count wraps to BOTTOM
						cmp_a_nxt = cmp_a_buf_r;
						cmp_b_nxt = cmp_b_buf_r;
					end
				end
				WF_DUAL: begin
					// TOP and BOTTOM each last one tick; the count turns without a repeat
					if (up_r) begin
						count_nxt = at_top ? count_r - 16'h0001
							: count_r + 16'h0001;
						up_nxt = !at_top;
					end else begin
						count_nxt = at_bottom ? count_r + 16'h0001
							: count_r - 16'h0001;
						up_nxt = at_bottom;
					end
					if (at_top && mode.upd == UPD_TOP) begin
						cmp_a_nxt = cmp_a_buf_r;
						cmp_b_nxt = cmp_b_buf_r;
					end
					if (at_bottom) begin
						flags_nxt[FL_OVF] = 1'b1;
						if (mode.upd == UPD_BOTTOM) begin
							cmp_a_nxt = cmp_a_buf_r;
							cmp_b_nxt = cmp_b_buf_r;
						end
					end
				end
				default: count_nxt = count_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: take address and data in any order
	assign do_write = aw_r && w_r && !bvalid_r;
	assign wr_hit   = (awaddr_r == OFF_CONTROL_A) ||
		(awaddr_r == OFF_CONTROL_B_W) || (awaddr_r == OFF_COMPARE_A) ||
		(awaddr_r == OFF_COMPARE_B) || (awaddr_r == OFF_CAPTURE) ||
		(awaddr_r == OFF_FLAGS);

	always_comb begin
		aw_nxt = aw_r;
		w_nxt  = w_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt  = wdata_r;
		wstrb_nxt  = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		ctrl_a_nxt = ctrl_a_r;
		ctrl_b_nxt = ctrl_b_r;
		cmp_a_buf_nxt = cmp_a_buf_r;
		cmp_b_buf_nxt = cmp_b_buf_r;
		capture_nxt = capture_r;
		if (s_axi_awvalid_in && !aw_r) begin
			aw_nxt = 1'b1;
			awaddr_nxt = {s_axi_awaddr_in[7:2], 2'b00};
		end
		if (s_axi_wvalid_in && !w_r) begin
			w_nxt = 1'b1;
			wdata_nxt = s_axi_wdata_in;
			wstrb_nxt = s_axi_wstrb_in;
		end
		if (bvalid_r && s_axi_bready_in) bvalid_nxt = 1'b0;
		if (do_write) begin
			aw_nxt = 1'b0;
			w_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = wr_hit ? 2'b00 : 2'b10;
			if (wstrb_r[0]) begin
				case (awaddr_r)
					OFF_CONTROL_A:
						ctrl_a_nxt = wdata_r[7:0] & CONTROL_A_MASK;
					OFF_CONTROL_B_W:
						ctrl_b_nxt = wdata_r[7:0] & CONTROL_B_MASK;
					OFF_COMPARE_A: cmp_a_buf_nxt[7:0] = wdata_r[7:0];
					OFF_COMPARE_B: cmp_b_buf_nxt[7:0] = wdata_r[7:0];
					OFF_CAPTURE:   capture_nxt[7:0]   = wdata_r[7:0];
					default: ;
				endcase
			end
			if (wstrb_r[1]) begin
				case (awaddr_r)
					OFF_COMPARE_A: cmp_a_buf_nxt[15:8] = wdata_r[15:8];
					OFF_COMPARE_B: cmp_b_buf_nxt[15:8] = wdata_r[15:8];
					OFF_CAPTURE:   capture_nxt[15:8]   = wdata_r[15:8];
					default: ;
				endcase
			end
		end
	end

	// Read side: one read at a time, answered a cycle after address
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rvalid_r && s_axi_rready_in) rvalid_nxt = 1'b0;
		if (s_axi_arvalid_in && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = 2'b00;
			case ({s_axi_araddr_in[7:2], 2'b00})
				OFF_CONTROL_A:   rdata_nxt = {24'h000000, ctrl_a_r};
				OFF_CONTROL_B_W: rdata_nxt = {24'h000000, ctrl_b_r};
				OFF_COMPARE_A:   rdata_nxt = {16'h0000, cmp_a_buf_r};
				OFF_COMPARE_B:   rdata_nxt = {16'h0000, cmp_b_buf_r};
				OFF_CAPTURE:     rdata_nxt = {16'h0000, capture_r};
				OFF_COUNT:       rdata_nxt = {16'h0000, count_r};
				OFF_FLAGS:       rdata_nxt = {29'h00000000, flags_r};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = 2'b10;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Compare-output units
	wave_unit u_wave_a (
		.clock_in        (clock_in),
		.resetn_in       (resetn_in),
		.action_in       (ctrl_a_r[CA_ACT_A_LSB +: 2]),
		.mode_in         (mode),
		.is_chan_a_in    (1'b1),
		.tick_in         (tick),
		.match_in        (count_r == cmp_a_r),
		.at_bottom_in    (count_nxt == BOTTOM && at_top),
		.match_is_top_in (cmp_a_r == top && ctrl_a_r[CA_ACT_A_LSB + 1]),
		// Direction after the turn: TOP acts as falling, BOTTOM as rising
		.count_up_in     (up_nxt),
		.pin_out         (ctl_a)
	);

	wave_unit u_wave_b (
		.clock_in        (clock_in),
		.resetn_in       (resetn_in),
		.action_in       (ctrl_a_r[CA_ACT_B_LSB +: 2]),
		.mode_in         (mode),
		.is_chan_a_in    (1'b0),
		.tick_in         (tick),
		.match_in        (count_r == cmp_b_r),
		.at_bottom_in    (count_nxt == BOTTOM && at_top),
		.match_is_top_in (cmp_b_r == top && ctrl_a_r[CA_ACT_B_LSB + 1]),
		.count_up_in     (up_nxt),
		.pin_out         (ctl_b)
	);

	////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_a_r <= CONTROL_A_RESET;
			ctrl_b_r <= CONTROL_B_RESET;
			cmp_a_buf_r <= 16'h0000;
			cmp_b_buf_r <= 16'h0000;
			cmp_a_r <= 16'h0000;
			cmp_b_r <= 16'h0000;
			capture_r <= 16'h0000;
			count_r <= BOTTOM;
			up_r <= 1'b1;
			flags_r <= 3'h0;
			match_a_r <= 1'b0;
			match_b_r <= 1'b0;
			aw_r <= 1'b0;
			w_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'b00;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'b00;
			pre_r <= 10'h000;
			ext_sync_r <= 3'h0;
			port_a_sync_r <= 2'h0;
			port_b_sync_r <= 2'h0;
			pin_a_r <= 1'b0;
			pin_b_r <= 1'b0;
		end else begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
			cmp_a_buf_r <= cmp_a_buf_nxt;
			cmp_b_buf_r <= cmp_b_buf_nxt;
			cmp_a_r <= cmp_a_nxt;
			cmp_b_r <= cmp_b_nxt;
			capture_r <= capture_nxt;
			count_r <= count_nxt;
			up_r <= up_nxt;
			flags_r <= flags_nxt;
			match_a_r <= match_a_nxt;
			match_b_r <= match_b_nxt;
			aw_r <= aw_nxt;
			w_r <= w_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			pre_r <= pre_nxt;
			ext_sync_r <= {ext_sync_r[1:0], ext_tick_pin_in};
			port_a_sync_r <= {port_a_sync_r[0], port_a_level_in};
			port_b_sync_r <= {port_b_sync_r[0], port_b_level_in};
			// Compare output overrides port value when connected
			pin_a_r <= ctl_a.connect ? ctl_a.level : port_a_sync_r[1];
			pin_b_r <= ctl_b.connect ? ctl_b.level : port_b_sync_r[1];
		end
	end

	assign s_axi_awready_out = !aw_r;
	assign s_axi_wready_out  = !w_r;
	assign s_axi_bvalid_out  = bvalid_r;
	assign s_axi_bresp_out   = bresp_r;
	assign s_axi_arready_out = !rvalid_r;
	assign s_axi_rvalid_out  = rvalid_r;
	assign s_axi_rdata_out   = rdata_r;
	assign s_axi_rresp_out   = rresp_r;
	assign compare_out_a_out = pin_a_r;
	assign compare_out_b_out = pin_b_r;

endmodule

// ---- timer16_props.sv ----
/* Checker for timer16_core: register reads and compare pin behaviour.
   Assumes write address and data are offered and taken together. */
`timescale 1ns/1ps
module timer16_props
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic        clock_in,
	input wire logic        resetn_in,
	// Register bus
	input wire logic [7:0]  s_axi_awaddr_in,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [7:0]  s_axi_araddr_in,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	// Pins
	input wire logic        port_a_level_in,
	input wire logic        port_b_level_in,
	input wire logic        compare_out_a_out,
	input wire logic        compare_out_b_out
);
	logic [7:0] ra_r;  // Pending read address
	logic [7:0] ca_r;  // Control A shadow
	logic [7:0] cb_r;  // Control B shadow
	logic [3:0] md;    // Waveform mode
	logic       npw;   // Non-PWM mode
	logic       wt;    // Write taken
	logic       con_a; // Pin A owned by compare unit
	logic       con_b; // Pin B owned by compare unit
	assign md = {cb_r[4:3], ca_r[1:0]};
	assign npw = md inside {4'h0, 4'h4, 4'hC};
	assign wt = s_axi_wvalid_in && s_axi_wready_out;
	// PWM toggle is legal on channel A in four modes only
	assign con_a = md != 4'hD && ca_r[7:6] != ACT_OFF && (npw
		|| ca_r[7:6] != ACT_TOGGLE || md inside {4'h9, 4'hB, 4'hE, 4'hF});
	assign con_b = md != 4'hD && ca_r[5:4] != ACT_OFF && (npw
		|| ca_r[5:4] != ACT_TOGGLE);
	// Shadows follow accepted bus traffic
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ra_r <= 8'h00;
			ca_r <= 8'h00;
			cb_r <= 8'h00;
		end else begin
			if (s_axi_arvalid_in && s_axi_arready_out)
				ra_r <= s_axi_araddr_in;
			if (wt && s_axi_awaddr_in == OFF_CONTROL_A)
				ca_r <= s_axi_wdata_in[7:0] & CONTROL_A_MASK;
			if (wt && s_axi_awaddr_in == OFF_CONTROL_B_W)
				cb_r <= s_axi_wdata_in[7:0] & CONTROL_B_MASK;
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking dck @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);
	AST_CA_READ: assert property (s_axi_rvalid_out && ra_r == OFF_CONTROL_A
		|-> s_axi_rdata_out[31:8] == 24'h0 && s_axi_rdata_out[3:2] == 2'h0)
		else $error("control A read shows reserved bits");
	AST_READ_ANS: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out) else $error("read not answered");
	AST_READ_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read answer dropped");
	AST_PORT_A: assert property ((!con_a && $stable({ca_r, cb_r,
		port_a_level_in}))[*5] |-> compare_out_a_out == port_a_level_in)
		else $error("pin A not following port");
	AST_PORT_B: assert property ((!con_b && $stable({ca_r, cb_r,
		port_b_level_in}))[*5] |-> compare_out_b_out == port_b_level_in)
		else $error("pin B not following port");
	AST_CLEAR: assert property ((npw && ca_r[7:6] == ACT_CLEAR
		&& $stable({ca_r, cb_r}))[*4] |-> !$rose(compare_out_a_out))
		else $error("cleared pin rose");
	AST_SET: assert property ((npw && ca_r[7:6] == ACT_SET
		&& $stable({ca_r, cb_r}))[*4] |-> !$fell(compare_out_a_out))
		else $error("set pin fell");
	AST_STOP: assert property ((cb_r[2:0] == CS_STOP && con_a
		&& $stable({ca_r, cb_r}))[*4] |-> $stable(compare_out_a_out))
		else $error("pin A moved while stopped");
	COV_TOGGLE: cover property (con_a && $changed(compare_out_a_out));
	COV_RSVD: cover property (md == 4'hD && compare_out_a_out);
	COV_READ: cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule

bind timer16_core timer16_props u_props (.*);

// ---- tb_top.sv ----
/* Bench for timer16_core: register bus traffic and pin waveforms.
   Assumes the checker is bound to the core by its own file. */
`timescale 1ns/1ps
module tb_top;
	import timer16_pkg::*;
	// Design ports, joined by name
	logic        clock_in, resetn_in, ext_tick_pin_in;
	logic        port_a_level_in, port_b_level_in;
	logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic        s_axi_arvalid_in, s_axi_rready_in;
	logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv, c0;
	logic [3:0]  s_axi_wstrb_in;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic        s_axi_arready_out, s_axi_rvalid_out;
	logic        compare_out_a_out, compare_out_b_out;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rs;
	int          n_mismatch, n_compared, cyc;

	timer16_core DUT (.*);

	always #12.5 clock_in = ~clock_in;
	// Hang guard
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= 4'hF;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		rs = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		rv = s_axi_rdata_out;
		rs = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
		@(posedge clock_in);
	endtask
	// Cycles until pin A changes, capped
	task automatic gap(output int n);
		logic v;
		v = compare_out_a_out;
		n = 0;
		while (compare_out_a_out === v && n < 2048) begin
			@(posedge clock_in);
			n++;
		end
	endtask
	task automatic wave(input int hi, input int lo);
		int n;
		logic v;
		gap(n);
		gap(n);
		repeat (2) begin
			v = compare_out_a_out;
			gap(n);
			chk("pulse", v ? hi : lo, n);
		end
	endtask
	task automatic steady(input logic lv);
		int n;
		repeat (768) @(posedge clock_in);
		gap(n);
		chk("steady", 2048, n);
		chk("level", {31'h0, lv}, {31'h0, compare_out_a_out});
	endtask
	// Stop first so a mode change never sees a running count
	task automatic cfg(input logic [15:0] c, input logic [7:0] a,
		input logic [7:0] b);
		wr(OFF_CONTROL_B_W, 32'h0);
		wr(OFF_COMPARE_A, {16'h0, c});
		wr(OFF_CONTROL_A, {24'h0, a});
		wr(OFF_CONTROL_B_W, {24'h0, b});
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(OFF_CONTROL_A);
		chk("ctl_a rst", {24'h0, CONTROL_A_RESET}, rv);
		wr(OFF_CONTROL_A, 32'hFF);
		rd(OFF_CONTROL_A);
		chk("ctl_a", 32'hF3, rv);
		chk("rresp", 32'h0, {30'h0, rs});
		wr(8'hFC, 32'h1);
		chk("bresp", 32'h2, {30'h0, rs});
	endtask
	task automatic t_ctc();
		cfg(16'h001F, 8'h40, 8'h09);
		wave(32, 32);
		wr(OFF_CONTROL_A, 32'hC0);
		steady(1'b1);
		wr(OFF_CONTROL_A, 32'h80);
		steady(1'b0);
	endtask
	task automatic t_fast();
		cfg(16'h001F, 8'h53, 8'h19);
		wave(32, 32);
		port_b_level_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		chk("pin b", 32'h1, {31'h0, compare_out_b_out});
		cfg(16'h003F, 8'h81, 8'h09);
		wave(64, 192);
		wr(OFF_CONTROL_A, 32'hC1);
		wave(192, 64);
		wr(OFF_COMPARE_A, 32'hFF);
		wr(OFF_CONTROL_A, 32'h81);
		steady(1'b1);
	endtask
	task automatic t_dual();
		cfg(16'h0040, 8'h81, 8'h01);
		wave(128, 382);
		wr(OFF_COMPARE_A, 32'h0);
		steady(1'b0);
	endtask
	task automatic t_rsvd();
		cfg(16'h0010, 8'h81, 8'h19);
		port_a_level_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		chk("pin a", 32'h1, {31'h0, compare_out_a_out});
	endtask
	task automatic t_ext();
		cfg(16'h0000, 8'h00, 8'h00);
		rd(OFF_COUNT);
		c0 = rv;
		wr(OFF_CONTROL_B_W, {29'h0, CS_EXT_RISE});
		repeat (5) begin
			ext_tick_pin_in <= 1'b1;
			repeat (4) @(posedge clock_in);
			ext_tick_pin_in <= 1'b0;
			repeat (4) @(posedge clock_in);
		end
		rd(OFF_COUNT);
		chk("ticks", 32'h5, rv - c0);
		// Stopped counter: earlier scenarios left all three flags set
		wr(OFF_CONTROL_B_W, 32'h0);
		rd(OFF_FLAGS);
		chk("flags", 32'h7, rv);
		wr(OFF_FLAGS, 32'h7);
		rd(OFF_FLAGS);
		chk("flags clr", 32'h0, rv);
	endtask
	initial begin
		clock_in = 1'b0;
		resetn_in = 1'b0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
		{s_axi_arvalid_in, s_axi_rready_in, ext_tick_pin_in} = 3'h0;
		{port_a_level_in, port_b_level_in} = 2'h0;
		{s_axi_awaddr_in, s_axi_araddr_in} = 16'h0;
		s_axi_wdata_in = 32'h0;
		s_axi_wstrb_in = 4'hF;
		repeat (6) @(posedge clock_in);
		resetn_in <= 1'b1;
		@(posedge clock_in);
		t_regs();
		t_ctc();
		t_fast();
		t_dual();
		t_rsvd();
		t_ext();
		conclude();
	end
endmodule
